// *** hdl/lsrt_regs.vh ***
`ifndef LSRT_REGS_VH
`define LSRT_REGS_VH

`define LSRT_CELL_BITS    16
`define LSRT_CELLS        8
`define LSRT_MAX_BITS     128
`define LSRT_ADDR_BITS    7

// Register byte offsets
`define LSRT_CTRL_OFS     12'h000
`define LSRT_INIT_OFS     12'h004
`define LSRT_STAT_OFS     12'h008
`define LSRT_DATA0_OFS    12'h010
`define LSRT_DATA1_OFS    12'h014
`define LSRT_DATA2_OFS    12'h018
`define LSRT_DATA3_OFS    12'h01C

// CTRL fields
`define LSRT_CTRL_CLKINV  0
`define LSRT_CTRL_GATEINV 1
`define LSRT_CTRL_LEN_LO  2
`define LSRT_CTRL_LEN_HI  3
`define LSRT_CTRL_RELOAD  4

// Length codes
`define LSRT_LEN_16       2'h0
`define LSRT_LEN_32       2'h1
`define LSRT_LEN_64       2'h2
`define LSRT_LEN_128      2'h3

// Reset values
`define LSRT_CTRL_RST     5'h0C
`define LSRT_INIT_RST     16'h0000

`endif

// *** hdl/lsrt_shift_tap.v ***
// Our own choices: the address map and the APB register port.
`timescale 1ns/10ps
`include "lsrt_regs.vh"

module lsrt_shift_tap (
   input  wire         pclk,
   input  wire         presetn,
   input  wire         psel,
   input  wire         penable,
   input  wire         pwrite,
   input  wire [11:0]  paddr,
   input  wire [31:0]  pwdata,
   output reg  [31:0]  prdata,
   output reg          pready,
   output reg          pslverr,
   input  wire         shift_clk,
   input  wire         shift_data,
   input  wire         shift_gate,
   input  wire [6:0]   tap_select,
   output reg          tap_out,
   output reg          cascade_out
);

   // =====================================================
   // Configuration registers
   reg  [4:0]   ctrl_reg;
   reg  [15:0]  init_reg;
   reg          reload_reg;
   wire         clk_inv   = ctrl_reg[`LSRT_CTRL_CLKINV];
   wire         gate_inv  = ctrl_reg[`LSRT_CTRL_GATEINV];
   wire [1:0]   len_sel   = ctrl_reg[`LSRT_CTRL_LEN_HI:`LSRT_CTRL_LEN_LO];

   // =====================================================
   // Bus decode
   // The answer comes one cycle after the first access cycle; a write is
   // applied only at the edge that ends the transfer, with pready high, so
   // the register update and the master's view of the transfer end agree.
   wire         access    = psel & penable & ~pready;
   wire         xfer_end  = psel & penable & pready;
   wire         wr_en     = xfer_end & pwrite;
   wire         hit_ctrl  = (paddr == `LSRT_CTRL_OFS);
   wire         hit_init  = (paddr == `LSRT_INIT_OFS);
   wire         ctrl_wr   = wr_en & hit_ctrl;
   wire         init_wr   = wr_en & hit_init;
   wire [1:0]   len_wr    = pwdata[`LSRT_CTRL_LEN_HI:`LSRT_CTRL_LEN_LO];

   // =====================================================
   // Shift clock synchroniser
   // The shift clock is unrelated to pclk. The first flop only catches
   // metastability; a level counts once the second and third agree.
   // Each level of the shift clock must last two pclk cycles or it is lost.
   reg          sclk_s1_reg;
   reg          sclk_s2_reg;
   reg          sclk_s3_reg;
   reg          sclk_stable_reg;
   wire         sclk_agree  = (sclk_s2_reg == sclk_s3_reg);
   wire         sclk_rise   = sclk_agree & sclk_s3_reg & ~sclk_stable_reg;
   wire         sclk_fall   = sclk_agree & ~sclk_s3_reg & sclk_stable_reg;
   wire         active_edge = clk_inv ? sclk_fall : sclk_rise;
   wire         gate_on     = shift_gate ^ gate_inv;
   wire         do_shift    = active_edge & gate_on;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_s1_reg     <= 1'b0;
         sclk_s2_reg     <= 1'b0;
         sclk_s3_reg     <= 1'b0;
         sclk_stable_reg <= 1'b0;
      end else begin
         sclk_s1_reg <= shift_clk;
         sclk_s2_reg <= sclk_s1_reg;
         sclk_s3_reg <= sclk_s2_reg;
         if (sclk_agree) begin
            sclk_stable_reg <= sclk_s3_reg;
         end
      end
   end

   // =====================================================
   // Length decode
   // The whole chain always shifts; length only masks the tap address and
   // picks which cell feeds the cascade output. Stages above the selected
   // length keep moving, which software sees in the upper data words.
   reg  [6:0]   addr_mask;
   always @* begin
      case (len_sel)
         `LSRT_LEN_16: begin
            addr_mask = 7'h0F;
         end
         `LSRT_LEN_32: begin
            addr_mask = 7'h1F;
         end
         `LSRT_LEN_64: begin
            addr_mask = 7'h3F;
         end
         default: begin
            addr_mask = 7'h7F;
         end
      endcase
   end

   wire [6:0]   tap_idx = tap_select & addr_mask;

   // =====================================================
   // Stage storage
   // Stages come up from the initial content on reset; there is no other
   // set/reset path into them, so a global set/reset cannot disturb them.
   reg  [`LSRT_MAX_BITS-1:0] stage_reg;
   reg  [`LSRT_MAX_BITS-1:0] stage_next;
   wire [`LSRT_MAX_BITS-1:0] init_image;
   wire [7:0]                cell_last;
   wire [7:0]                cell_tap;

   // Per cell: initial image, last stage and a four-level lookup tree
   genvar c;
   genvar k;
   generate
      for (c = 0; c < `LSRT_CELLS; c = c + 1) begin : g_cell
         wire [15:0] cell_word = stage_reg[c*16 +: 16];
         wire [7:0]  lut_l1;
         wire [3:0]  lut_l2;
         wire [1:0]  lut_l3;
         assign init_image[c*16 +: 16] = init_reg;
         assign cell_last[c]           = cell_word[15];
         for (k = 0; k < 8; k = k + 1) begin : g_l1
            assign lut_l1[k] = tap_idx[0] ? cell_word[2*k+1] : cell_word[2*k];
         end
         for (k = 0; k < 4; k = k + 1) begin : g_l2
            assign lut_l2[k] = tap_idx[1] ? lut_l1[2*k+1] : lut_l1[2*k];
         end
         for (k = 0; k < 2; k = k + 1) begin : g_l3
            assign lut_l3[k] = tap_idx[2] ? lut_l2[2*k+1] : lut_l2[2*k];
         end
         assign cell_tap[c] = tap_idx[3] ? lut_l3[1] : lut_l3[0];
      end
   endgenerate

   // Reload wins over a shift in the same cycle; that shifted bit is lost.
   // A shift moves every bit one stage up and drops the top stage.
   always @* begin
      stage_next = stage_reg;
      if (reload_reg) begin
         stage_next = init_image;
      end else if (do_shift) begin
         stage_next = {stage_reg[`LSRT_MAX_BITS-2:0], shift_data};
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage_reg <= {`LSRT_CELLS{`LSRT_INIT_RST}};
      end else begin
         stage_reg <= stage_next;
      end
   end

   // =====================================================
   // Tap selection tree
   // Three levels of 2:1 selectors join the cell taps, each level taking
   // one more address bit, as a cascaded chain of cells would.
   // Address bits above the selected length are already masked off.
   wire [3:0]   pair_tap;
   wire [1:0]   quad_tap;
   wire         tap_next;
   reg          cascade_next;

   generate
      for (c = 0; c < 4; c = c + 1) begin : g_sel1
         assign pair_tap[c] = tap_idx[4] ? cell_tap[2*c+1] : cell_tap[2*c];
      end
      for (c = 0; c < 2; c = c + 1) begin : g_sel2
         assign quad_tap[c] = tap_idx[5] ? pair_tap[2*c+1] : pair_tap[2*c];
      end
   endgenerate
   assign tap_next = tap_idx[6] ? quad_tap[1] : quad_tap[0];

   // Cascade output is the last cell in use, never touched by the tap
   always @* begin
      case (len_sel)
         `LSRT_LEN_16: begin
            cascade_next = cell_last[0];
         end
         `LSRT_LEN_32: begin
            cascade_next = cell_last[1];
         end
         `LSRT_LEN_64: begin
            cascade_next = cell_last[3];
         end
         default: begin
            cascade_next = cell_last[7];
         end
      endcase
   end

   // =====================================================
   // Outputs
   // Both outputs come from flops, so an address change or a shift shows
   // one pclk later; a user expecting bare lookup timing must allow for it.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tap_out     <= 1'b0;
         cascade_out <= 1'b0;
      end else begin
         tap_out     <= tap_next;
         cascade_out <= cascade_next;
      end
   end

   // =====================================================
   // Register read
   // Data word n holds stages 32n to 32n+31, the lowest stage in bit 0
   reg  [31:0]  rd_mux;
   reg          addr_ok;
   wire [31:0]  stat_word = {30'h0, cascade_out, tap_out};
   wire [31:0]  data_word [0:3];

   generate
      for (c = 0; c < 4; c = c + 1) begin : g_word
         assign data_word[c] = stage_reg[c*32 +: 32];
      end
   endgenerate

   always @* begin
      rd_mux  = 32'h0000_0000;
      addr_ok = 1'b1;
      case (paddr)
         `LSRT_CTRL_OFS: begin
            rd_mux = {27'h0, ctrl_reg};
         end
         `LSRT_INIT_OFS: begin
            rd_mux = {16'h0, init_reg};
         end
         `LSRT_STAT_OFS: begin
            rd_mux = stat_word;
         end
         `LSRT_DATA0_OFS: begin
            rd_mux = data_word[0];
         end
         `LSRT_DATA1_OFS: begin
            rd_mux = data_word[1];
         end
         `LSRT_DATA2_OFS: begin
            rd_mux = data_word[2];
         end
         `LSRT_DATA3_OFS: begin
            rd_mux = data_word[3];
         end
         default: begin
            addr_ok = 1'b0;
         end
      endcase
   end

   // =====================================================
   // Bus response, one wait state per transfer
   // Read data is zero outside the answer cycle, so idle cycles show no stale word
   reg          pready_next;
   reg          pslverr_next;
   reg  [31:0]  prdata_next;
   always @* begin
      pready_next  = access;
      pslverr_next = access & ~addr_ok;
      prdata_next  = 32'h0000_0000;
      if (access && !pwrite) begin
         prdata_next = rd_mux;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= pready_next;
         pslverr <= pslverr_next;
         prdata  <= prdata_next;
      end
   end

   // =====================================================
   // Configuration writes
   // The reload bit is not stored: it makes a one-cycle pulse that copies
   // the initial content into every cell at the following edge.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg   <= `LSRT_CTRL_RST;
         init_reg   <= `LSRT_INIT_RST;
         reload_reg <= 1'b0;
      end else begin
         reload_reg <= ctrl_wr & pwdata[`LSRT_CTRL_RELOAD];
         if (ctrl_wr) begin
            ctrl_reg[`LSRT_CTRL_CLKINV]                   <= pwdata[`LSRT_CTRL_CLKINV];
            ctrl_reg[`LSRT_CTRL_GATEINV]                  <= pwdata[`LSRT_CTRL_GATEINV];
            ctrl_reg[`LSRT_CTRL_LEN_HI:`LSRT_CTRL_LEN_LO] <= len_wr;
            ctrl_reg[`LSRT_CTRL_RELOAD]                   <= 1'b0;
         end
         if (init_wr) begin
            init_reg <= pwdata[15:0];
         end
      end
   end

endmodule

// *** verification/lsrt_monitor.sv ***
`timescale 1ns/10ps
// ==========
// APB and output checks
module lsrt_monitor (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        shift_clk,
   input wire logic [6:0]  tap_select,
   input wire logic        tap_out,
   input wire logic        cascade_out
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_pulse: assert property (pready |=> !pready) else $error("long pready");
   a_access_answer: assert property (psel && penable && !pready |=> pready)
      else $error("no answer");
   a_ready_needs_sel: assert property (!psel |=> !pready) else $error("stray pready");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata idle");
   a_err_with_ready: assert property (pslverr |-> pready) else $error("lone pslverr");
   a_err_rdata_zero: assert property (pslverr |-> prdata == 32'h0) else $error("err data");
   // Settle span covers the three-flop sync plus output register
   a_tap_holds: assert property (($stable(shift_clk) && $stable(tap_select) && !psel)[*8]
      |-> $stable(tap_out)) else $error("tap moved");
   a_cascade_holds: assert property (($stable(shift_clk) && !psel)[*8]
      |-> $stable(cascade_out)) else $error("cascade moved");
endmodule

bind lsrt_shift_tap lsrt_monitor mon_u (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .shift_clk(shift_clk), .tap_select(tap_select), .tap_out(tap_out),
   .cascade_out(cascade_out));

// *** verification/lsrt_user.sv ***
`timescale 1ns/10ps
// ==========
// Surrounding user logic
module lsrt_user (
   input  wire logic pclk,
   input  wire logic tap_out,
   output logic      shift_clk,
   output logic      shift_data,
   output logic      shift_gate,
   output logic      tap_q
);
   initial begin
      shift_clk = 1'b0;
      shift_data = 1'b0;
      shift_gate = 1'b0;
   end
   always @(posedge pclk) tap_q <= tap_out;
   // Each level lasts past the sync delay; clock idles low
   task automatic shift(input logic d, input logic g);
      @(posedge pclk);
      shift_data <= d;
      shift_gate <= g;
      shift_clk <= 1'b1;
      repeat (5) @(posedge pclk);
      shift_clk <= 1'b0;
      repeat (6) @(posedge pclk);
      shift_data <= ~d;
   endtask
endmodule

// *** verification/lsrt_shift_tap_bench.sv ***
`timescale 1ns/10ps
// ==========
// Register and shift sequences
module lsrt_shift_tap_bench;
   logic        pclk, presetn, psel, penable, pwrite, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, rd;
   logic [6:0]  tap_select;
   wire  [31:0] prdata;
   wire         pready, pslverr, shift_clk, shift_data, shift_gate, tap_out, cascade_out;
   int          fails, checked;
   lsrt_shift_tap dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .shift_clk(shift_clk), .shift_data(shift_data),
      .shift_gate(shift_gate), .tap_select(tap_select), .tap_out(tap_out),
      .cascade_out(cascade_out));
   lsrt_user user_u (.pclk(pclk), .tap_out(tap_out), .shift_clk(shift_clk),
      .shift_data(shift_data), .shift_gate(shift_gate), .tap_q());
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic close_out;
      $display("fails %0d checked %0d", fails, checked);
      if (fails == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         fails++;
         $display("wrong value t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      cmp(rd, e);
   endtask
   task automatic tap(input logic [6:0] s, input logic e);
      tap_select <= s;
      repeat (3) @(posedge pclk);
      cmp({31'h0, tap_out}, {31'h0, e});
      @(posedge pclk);
      cmp({31'h0, user_u.tap_q}, {31'h0, e});
   endtask
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, tap_select} = '0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      chk(12'h000, 32'h0000000C);
      chk(12'h004, 32'h0);
      chk(12'h010, 32'h0);
      chk(12'h020, 32'h0);
      cmp({31'h0, err}, 32'h1);
      apb(1'b1, 12'h004, 32'h0000A5C3);
      apb(1'b1, 12'h000, 32'h00000010);
      chk(12'h010, 32'hA5C3A5C3);
      cmp({31'h0, cascade_out}, 32'h1);
      user_u.shift(1'b1, 1'b0);
      chk(12'h010, 32'hA5C3A5C3);
      user_u.shift(1'b0, 1'b1);
      chk(12'h010, 32'h4B874B86);
      cmp({31'h0, cascade_out}, 32'h0);
      for (int i = 0; i < 16; i++)
         tap(i[6:0], 1'((32'h4B874B86 >> i) & 1));
      tap(7'h10, 1'b0);
      apb(1'b1, 12'h000, 32'h00000002);
      user_u.shift(1'b1, 1'b0);
      chk(12'h010, 32'h970E970D);
      apb(1'b1, 12'h000, 32'h00000003);
      user_u.shift(1'b1, 1'b0);
      chk(12'h010, 32'h2E1D2E1B);
      chk(12'h014, 32'h2E1D2E1D);
      apb(1'b1, 12'h000, 32'h0000000B);
      tap(7'h27, 1'b0);
      tap(7'h26, 1'b0);
      tap(7'h23, 1'b1);
      apb(1'b1, 12'h000, 32'h0000000F);
      tap(7'h41, 1'b0);
      apb(1'b1, 12'h000, 32'h00000007);
      tap(7'h10, 1'b1);
      close_out();
   end
   initial begin
      #200000;
      fails++;
      close_out();
   end
endmodule
